// File: wdt_top.sv
// Watchdog timer core: prescaler, 16-bit up-counter, failure sequence.
// Assumes commands arrive as one-cycle pulses from core-clock logic.
`timescale 1ns/1ns
`default_nettype none

module wdt_top
  import wdt_pkg::*;
(
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_clk_en,
  input  wire wdt_cmd_s         i_cmd,
  output logic                  o_prewarn_irq,
  output logic                  o_reset_req,
  output logic                  o_enabled,
  output logic [CNT_W-1:0]      o_count
);

  //////////////////////////////////////////////////////////////////////////

  // Last prescaler value before a tick
  function automatic logic [PRESC_W-1:0] presc_top(input logic sel);
    presc_top = (sel == PSEL_SLOW) ? PRESC_W'(DIV_SLOW - 1)
                                   : PRESC_W'(DIV_FAST - 1);
  endfunction

  wdt_state_s st_reg;
  wdt_state_s st_next;
  logic       tick;
  logic       overflow;
  logic       service;

  assign service  = i_cmd.watchdog_service_cmd;
  assign tick     = st_reg.enabled
                    && (st_reg.presc == presc_top(st_reg.presc_sel));
  assign overflow = tick && !service && (st_reg.count == CNT_MAX);

  //////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next         = st_reg;
    st_next.prewarn = 1'b0;
    if (i_cmd.watchdog_enable_cmd) begin
      st_next.enabled = 1'b1;
    end else if (i_cmd.watchdog_disable_cmd) begin
      st_next.enabled = 1'b0;
    end
    if (i_cmd.reload_wr) begin
      st_next.reload = i_cmd.watchdog_reload_value;
    end
    if (i_cmd.presc_wr) begin
      st_next.presc_sel = i_cmd.presc_sel;
    end
    if (st_reg.mode != WDT_RESET_REQ) begin
      if (service) begin
        st_next.count = st_reg.reload;
        st_next.presc = PRESC_RST;
        st_next.mode  = WDT_RUN;
      end else if (st_reg.enabled) begin
        if (tick) begin
          st_next.presc = PRESC_RST;
          st_next.count = st_reg.count + 16'h0001;
        end else begin
          st_next.presc = st_reg.presc + 14'h0001;
        end
        if (overflow) begin
          if (st_reg.mode == WDT_RUN) begin
            st_next.prewarn = 1'b1;
            st_next.mode    = WDT_WARNED;
          end else begin
            st_next.reset_req = 1'b1;
            st_next.mode      = WDT_RESET_REQ;
          end
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st_reg.mode      <= WDT_RUN;
      st_reg.enabled   <= 1'b1;
      st_reg.presc_sel <= PSEL_RST;
      st_reg.reload    <= RELOAD_RST;
      st_reg.count     <= RELOAD_RST;
      st_reg.presc     <= PRESC_RST;
      st_reg.prewarn   <= 1'b0;
      st_reg.reset_req <= 1'b0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_prewarn_irq = st_reg.prewarn;
  assign o_reset_req   = st_reg.reset_req;
  assign o_enabled     = st_reg.enabled;
  assign o_count       = st_reg.count;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_ovf_first;
    i_clk_en && overflow && st_reg.mode == WDT_RUN;
  endsequence

  sequence s_warn_out;
    o_prewarn_irq && !o_reset_req && o_count == 16'h0000;
  endsequence

  property p_reset_up;
    $past(!i_nrst) |-> o_enabled && o_count == RELOAD_RST && !o_reset_req;
  endproperty
  a_reset_up: assert property (p_reset_up)
    else $error("not up after reset");

  property p_disable;
    i_clk_en && i_cmd.watchdog_disable_cmd && !i_cmd.watchdog_enable_cmd
      |=> !o_enabled;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable ignored");

  property p_enable;
    i_clk_en && i_cmd.watchdog_enable_cmd |=> o_enabled;
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable ignored");

  property p_prewarn_first;
    s_ovf_first |=> s_warn_out ##1 !o_prewarn_irq;
  endproperty
  a_prewarn_first: assert property (p_prewarn_first)
    else $error("no prewarn");

  property p_reset_after_warn;
    $rose(o_reset_req) |-> $past(st_reg.mode == WDT_WARNED) && !o_prewarn_irq;
  endproperty
  a_reset_after_warn: assert property (p_reset_after_warn)
    else $error("reset without prewarn");

  property p_count_on_tick;
    i_clk_en && !tick && !service |=> $stable(o_count);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick)
    else $error("count moved without tick");

  property p_tick_div;
    tick |-> st_reg.presc == (st_reg.presc_sel ? 14'h3fff : 14'h00ff);
  endproperty
  a_tick_div: assert property (p_tick_div)
    else $error("bad divide");

  property p_service;
    i_clk_en && service && st_reg.mode != WDT_RESET_REQ
      |=> o_count == $past(st_reg.reload) && st_reg.presc == 14'h0000;
  endproperty
  a_service: assert property (p_service)
    else $error("service no reload");

  property p_reload_wr;
    i_clk_en && i_cmd.reload_wr
      |=> st_reg.reload == $past(i_cmd.watchdog_reload_value);
  endproperty
  a_reload_wr: assert property (p_reload_wr)
    else $error("reload lost");

  property p_defaults;
    $past(!i_nrst) |-> st_reg.presc_sel == PSEL_FAST
      && st_reg.reload == 16'hff02;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("bad defaults");

  property p_wrap;
    i_clk_en && overflow |=> o_count == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_hold_disabled;
    i_clk_en && !o_enabled && !i_cmd.watchdog_enable_cmd && !service
      |=> $stable(o_count) && $stable(st_reg.presc) && !o_prewarn_irq
          && $stable(o_reset_req);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("moved while disabled");

  // Service outside the final failure state
  sequence s_serviced;
    i_clk_en && service && st_reg.mode != WDT_RESET_REQ;
  endsequence

  property p_service_run;
    s_serviced |=> st_reg.mode == WDT_RUN;
  endproperty
  a_service_run: assert property (p_service_run)
    else $error("service left warned mode");

  property p_reset_sticky;
    o_reset_req |=> o_reset_req;
  endproperty
  a_reset_sticky: assert property (p_reset_sticky)
    else $error("reset request dropped");

  property p_prewarn_pulse;
    i_clk_en && o_prewarn_irq |=> !o_prewarn_irq;
  endproperty
  a_prewarn_pulse: assert property (p_prewarn_pulse)
    else $error("prewarn longer than a cycle");

  property p_prewarn_cause;
    $rose(o_prewarn_irq) |-> $past(overflow);
  endproperty
  a_prewarn_cause: assert property (p_prewarn_cause)
    else $error("prewarn without overflow");

  // Clock enable low freezes everything
  property p_freeze;
    !i_clk_en |=> $stable(st_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");

  property p_presc_step;
    i_clk_en && o_enabled && !tick && !service
      && st_reg.mode != WDT_RESET_REQ
      |=> st_reg.presc == $past(st_reg.presc) + 14'h0001;
  endproperty
  a_presc_step: assert property (p_presc_step)
    else $error("prescaler did not step");

endmodule

`default_nettype wire

// File: wdt_pkg.sv
// Constants, types and carriers of the watchdog timer.
// Assumes a single core clock; commands come from same-clock logic.
package wdt_pkg;

  localparam int unsigned CNT_W       = 16;
  localparam int unsigned PRESC_W     = 14;
  localparam int unsigned DIV_SLOW    = 16384;
  localparam int unsigned DIV_FAST    = 256;

  localparam logic        PSEL_FAST   = 1'b0;
  localparam logic        PSEL_SLOW   = 1'b1;

  // Default interval, stated against a 10 MHz reference clock
  localparam int unsigned DEF_INTERVAL_US = 6500;
  localparam int unsigned REF_CLK_MHZ     = 10;
  localparam int unsigned DEF_TICKS       =
    (DEF_INTERVAL_US * REF_CLK_MHZ + DIV_FAST - 1) / DIV_FAST;

  localparam logic              PSEL_RST   = PSEL_FAST;
  localparam logic [CNT_W-1:0]  RELOAD_RST = CNT_W'(65536 - DEF_TICKS);
  localparam logic [CNT_W-1:0]  CNT_MAX    = 16'hffff;
  localparam logic [PRESC_W-1:0] PRESC_RST = 14'h0000;

  typedef enum logic [1:0] {
    WDT_RUN,
    WDT_WARNED,
    WDT_RESET_REQ
  } wdt_mode_e;

  typedef struct packed {
    logic             watchdog_service_cmd;
    logic             watchdog_enable_cmd;
    logic             watchdog_disable_cmd;
    logic             reload_wr;
    logic [CNT_W-1:0] watchdog_reload_value;
    logic             presc_wr;
    logic             presc_sel;
  } wdt_cmd_s;

  typedef struct packed {
    wdt_mode_e          mode;
    logic               enabled;
    logic               presc_sel;
    logic [CNT_W-1:0]   reload;
    logic [CNT_W-1:0]   count;
    logic [PRESC_W-1:0] presc;
    logic               prewarn;
    logic               reset_req;
  } wdt_state_s;

endpackage

// File: wdt_cpu_model.sv
// Processor-side model issuing watchdog commands as one-cycle pulses.
// Assumes the bench calls issue() from procedural code, one at a time.
`timescale 1ns/1ns
`default_nettype none

module wdt_cpu_model
  import wdt_pkg::*;
(
  input  wire logic     i_core_clk,
  output var  wdt_cmd_s o_cmd
);
  initial o_cmd = '0;

  // one command pulse on request
  // Op bits: service, enable, disable, reload write, prescaler write
  task automatic issue(input logic [4:0] op, input logic [15:0] val,
                       input logic sel);
    @(negedge i_core_clk);
    o_cmd = {op[4:1], val, op[0], sel};
    @(negedge i_core_clk);
    o_cmd = '0;
  endtask
endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the watchdog timer core.
// Assumes wdt_top, wdt_pkg and wdt_cpu_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end

module testbench;
  import wdt_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_nrst     = 1'b0;
  logic        i_clk_en   = 1'b1;
  wdt_cmd_s    cmd;
  logic        pw, rr, en;
  logic [15:0] cnt, r, c;
  logic [31:0] seed = 32'h5cd12214;
  int          fails = 0, checks_done = 0, cyc = 0;

  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      test_done();
    end
  end

  wdt_cpu_model cpu (.i_core_clk(i_core_clk), .o_cmd(cmd));
  wdt_top dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_clk_en(i_clk_en), .i_cmd(cmd), .o_prewarn_irq(pw),
    .o_reset_req(rr), .o_enabled(en), .o_count(cnt));

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic int cycles_to_ovf(input logic [15:0] v, input int d);
    return (65536 - int'(v)) * d;
  endfunction

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // Load reload value, service, expect one prewarn pulse at overflow
  task automatic chk_ovf(input logic [15:0] v, input int d);
    cpu.issue(5'b00011, v, d == DIV_SLOW);
    cpu.issue(5'b10000, 16'h0000, 1'b0);
    `CHK(cnt, v)
    wait_n(cycles_to_ovf(v, d) - 1);
    `CHK(pw, 1'b0)
    wait_n(1);
    `CHK(pw, 1'b1)
    `CHK(cnt, 16'h0000)
    wait_n(1);
    `CHK(pw, 1'b0)
    `CHK(rr, 1'b0)
  endtask

  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    wait_n(16);
    i_nrst = 1'b1;
    `CHK(en, 1'b1)
    `CHK(cnt, 16'hff02)
    wait_n(255);
    `CHK(cnt, 16'hff02)
    wait_n(1);
    `CHK(cnt, 16'hff03)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      r = (i == 0) ? 16'hffff : (16'hfff0 | 16'(seed[3:0]));
      chk_ovf(r, DIV_FAST);
    end
    $display("test fast overflow done");
    chk_ovf(16'hffff, DIV_SLOW);
    cpu.issue(5'b00001, 16'h0000, 1'b0);
    $display("test slow overflow done");
    cpu.issue(5'b00100, 16'h0000, 1'b0);
    `CHK(en, 1'b0)
    c = cnt;
    wait_n(600);
    `CHK(cnt, c)
    `CHK(pw, 1'b0)
    cpu.issue(5'b01100, 16'h0000, 1'b0);
    `CHK(en, 1'b1)
    i_clk_en = 1'b0;
    cpu.issue(5'b00100, 16'h0000, 1'b0);
    `CHK(en, 1'b1)
    i_clk_en = 1'b1;
    $display("test enable control done");
    test_done();
  end
endmodule

`default_nettype wire
